// file: include/trip_logic_map.svh
// Constants for the unblock and permissive trip qualification block.
// Assumes a single bus clock and a millisecond timebase divided from it.
`ifndef TRIP_LOGIC_MAP_SVH
`define TRIP_LOGIC_MAP_SVH

// Timebase.
`define PCLK_PERIOD_NS 10
`define MS_PERIOD_NS 1000000

// Timer values in milliseconds.
`define PRE_TRIP_STEP_MS 2
`define HOLD_SHORT_MS 10
`define HOLD_MID_MS 50
`define HOLD_LONG_MS 100
`define UB_SHORT_MS 150
`define UB_MID_MS 300
`define UB_LONG_MS 500
`define LL_SHORT_MS 50
`define LL_MID_MS 75
`define LL_LONG_MS 100
`define GUARD_QUAL_MS 120
`define OVERRIDE_ARM_MS 1000
`define OVERRIDE_RESET_MS 200

// Switch field positions; bit n-1 is switch position n, closed reads 1.
`define A_PRE_LSB 0
`define A_PRE_MSB 3
`define A_TRIP_HOLD_LSB 4
`define A_GUARD_HOLD_LSB 6
`define B_UB_LSB 0
`define B_NOISE_BLOCK_BIT 2
`define B_GBT_LSB 3
`define C_LL_LSB 6

// Register map.
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define CTRL_RESET 1'b1
`define CTRL_ENABLE_BIT 0
`define ST_TRIP_BIT 0
`define ST_GUARD_BIT 1
`define ST_LOW_LEVEL_BIT 2
`define ST_LOC_BIT 3
`define ST_GUARD_OK_BIT 4
`define ST_ARMED_BIT 5
`define ST_UB_LSB 6

`endif

// file: include/trip_logic_pkg.sv
// Types shared by the trip qualification block.
// Assumes the map header supplies the numeric constants.
package trip_logic_pkg;

  // Bit 0 is bank B position 4, bit 1 is position 5.
  typedef enum logic [1:0] {
    GBT_OFF = 2'b00,
    GBT_NO_OVERRIDE = 2'b01,
    GBT_OVERRIDE = 2'b10,
    GBT_UNUSED = 2'b11
  } gbt_mode_type;

  typedef enum logic [1:0] {
    UB_IDLE = 2'b00,
    UB_WINDOW = 2'b01,
    UB_LOCKED = 2'b10
  } ub_state_type;

endpackage

// file: rtl/unblock_permissive_trip_logic.sv
// Trip qualification for the unblock and permissive overreach scheme.
// Assumes receiver detector levels and switch banks arrive asynchronously.
//
// Register access over APB and the register addresses were decided locally.
`include "trip_logic_map.svh"

module unblock_permissive_trip_logic
  import trip_logic_pkg::*;
#(
  parameter int TICK_CYCLES = `MS_PERIOD_NS / `PCLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trip_rx,
  input wire logic guard_rx,
  input wire logic low_level_rx,
  input wire logic noise_rx,
  input wire logic [7:0] dip_bank_a,
  input wire logic [7:0] dip_bank_b,
  input wire logic [7:0] dip_bank_c,
  output logic trip_out,
  output logic guard_out,
  output logic low_level_out
);

  localparam int MS_W = 11;
  localparam int SYNC_W = 4 + 8 + 5 + 2;
  localparam logic [MS_W-1:0] GUARD_QUAL = MS_W'(`GUARD_QUAL_MS);
  localparam logic [MS_W-1:0] ARM_MS = MS_W'(`OVERRIDE_ARM_MS);
  localparam logic [MS_W-1:0] REARM_MS = MS_W'(`OVERRIDE_RESET_MS);
  localparam logic [MS_W-1:0] SAT_MS = ARM_MS + MS_W'(1);

  // Shared by the trip and guard stretchers.
  function automatic logic [MS_W-1:0] hold_ms(input logic [1:0] sw);
    case (sw)
      2'b01: hold_ms = MS_W'(`HOLD_SHORT_MS);
      2'b10: hold_ms = MS_W'(`HOLD_MID_MS);
      2'b11: hold_ms = MS_W'(`HOLD_LONG_MS);
      default: hold_ms = '0;
    endcase
  endfunction

  // Counts whole milliseconds while the condition holds and saturates.
  function automatic logic [MS_W-1:0] run_ms(input logic [MS_W-1:0] cnt,
                                             input logic cond, input logic tick);
    if (!cond) begin
      run_ms = '0;
    end else if (tick && cnt != SAT_MS) begin
      run_ms = cnt + MS_W'(1);
    end else begin
      run_ms = cnt;
    end
  endfunction

  // Two-flop synchronisers; only used switch positions are brought in.
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync_in;
  assign sync_in = {trip_rx, guard_rx, low_level_rx, noise_rx, dip_bank_a,
                    dip_bank_b[4:0], dip_bank_c[7:6]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  logic trip_s;
  logic guard_s;
  logic ll_s;
  logic noise_s;
  logic [7:0] bank_a;
  logic [4:0] bank_b;
  logic [1:0] bank_c_hi;
  assign {trip_s, guard_s, ll_s, noise_s, bank_a, bank_b, bank_c_hi} = sync2_q;

  // Millisecond tick.
  logic [31:0] div_q;
  logic tick_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == 32'(TICK_CYCLES - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // Switch decoding.
  logic [MS_W-1:0] pre_ms;
  logic [MS_W-1:0] ub_ms;
  logic [MS_W-1:0] ll_ms;
  gbt_mode_type gbt_mode;
  logic noise_block;
  assign pre_ms = MS_W'(bank_a[`A_PRE_MSB:`A_PRE_LSB]) * MS_W'(`PRE_TRIP_STEP_MS);
  assign gbt_mode = gbt_mode_type'(bank_b[`B_GBT_LSB +: 2]);
  assign noise_block = bank_b[`B_NOISE_BLOCK_BIT];

  always_comb begin
    case (bank_b[`B_UB_LSB +: 2])
      2'b01: ub_ms = MS_W'(`UB_SHORT_MS);
      2'b10: ub_ms = MS_W'(`UB_MID_MS);
      2'b11: ub_ms = MS_W'(`UB_LONG_MS);
      default: ub_ms = '0;
    endcase
    case (bank_c_hi)
      2'b01: ll_ms = MS_W'(`LL_SHORT_MS);
      2'b10: ll_ms = MS_W'(`LL_MID_MS);
      2'b11: ll_ms = MS_W'(`LL_LONG_MS);
      default: ll_ms = '0;
    endcase
  end

  // Continuous-presence timers.
  logic [MS_W-1:0] trip_run_q;
  logic [MS_W-1:0] guard_run_q;
  logic [MS_W-1:0] ll_run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_run_q <= '0;
      guard_run_q <= '0;
      ll_run_q <= '0;
    end else begin
      trip_run_q <= run_ms(trip_run_q, trip_s, tick_q);
      guard_run_q <= run_ms(guard_run_q, guard_s, tick_q);
      ll_run_q <= run_ms(ll_run_q, ll_s, tick_q);
    end
  end

  logic trip_timed;
  logic ll_delayed;
  logic loc;
  assign trip_timed = trip_s && (trip_run_q >= pre_ms);
  assign ll_delayed = ll_s && (ll_run_q >= ll_ms);
  assign loc = ll_delayed && !guard_s;

  // Guard-before-trip qualification; a lost channel discards earlier guard.
  logic guard_ok_q;
  logic armed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_ok_q <= 1'b0;
    end else if (guard_run_q >= GUARD_QUAL) begin
      guard_ok_q <= 1'b1;
    end else if (loc) begin
      guard_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (gbt_mode != GBT_OVERRIDE) begin
      armed_q <= 1'b0;
    end else if (trip_run_q > ARM_MS) begin
      armed_q <= 1'b1;
    end else if (guard_run_q >= REARM_MS) begin
      armed_q <= 1'b0;
    end
  end

  // The unused code is treated as the stricter no-override setting.
  logic permit;
  always_comb begin
    case (gbt_mode)
      GBT_OFF: permit = 1'b1;
      GBT_OVERRIDE: permit = guard_ok_q || armed_q;
      default: permit = guard_ok_q;
    endcase
  end

  // Unblock window and lockout.
  ub_state_type ub_state_q;
  logic [MS_W-1:0] ub_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ub_state_q <= UB_IDLE;
      ub_cnt_q <= '0;
    end else begin
      case (ub_state_q)
        UB_IDLE: begin
          ub_cnt_q <= '0;
          if (loc && ub_ms != '0 && permit) begin
            ub_state_q <= UB_WINDOW;
          end
        end
        UB_WINDOW: begin
          if (!loc) begin
            ub_state_q <= UB_IDLE;
          end else if (ub_cnt_q >= ub_ms) begin
            ub_state_q <= UB_LOCKED;
          end else if (tick_q) begin
            ub_cnt_q <= ub_cnt_q + MS_W'(1);
          end
        end
        UB_LOCKED: begin
          if (guard_run_q >= GUARD_QUAL) begin
            ub_state_q <= UB_IDLE;
          end
        end
        default: ub_state_q <= UB_IDLE;
      endcase
    end
  end

  logic ub_trip;
  logic trip_raw;
  assign ub_trip = (ub_state_q == UB_WINDOW) && !(noise_block && noise_s);
  // Only the armed override may trip through a locked-out channel.
  assign trip_raw = ub_trip ||
                    (trip_timed && permit && (ub_state_q != UB_LOCKED || armed_q));

  // Output stretchers.
  logic [MS_W-1:0] trip_hold_q;
  logic [MS_W-1:0] guard_hold_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_hold_q <= '0;
    end else if (trip_raw) begin
      trip_hold_q <= hold_ms(bank_a[`A_TRIP_HOLD_LSB +: 2]);
    end else if (tick_q && trip_hold_q != '0) begin
      trip_hold_q <= trip_hold_q - MS_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_hold_q <= '0;
    end else if (guard_s) begin
      guard_hold_q <= hold_ms(bank_a[`A_GUARD_HOLD_LSB +: 2]);
    end else if (tick_q && guard_hold_q != '0) begin
      guard_hold_q <= guard_hold_q - MS_W'(1);
    end
  end

  // Register file.
  logic ctrl_enable_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_enable_q <= `CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == `CTRL_OFFSET) begin
      ctrl_enable_q <= pwdata[`CTRL_ENABLE_BIT];
    end
  end

  // Disabling the block drops every output toward the relay at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_out <= 1'b0;
      guard_out <= 1'b0;
      low_level_out <= 1'b0;
    end else begin
      trip_out <= ctrl_enable_q && (trip_raw || trip_hold_q != '0);
      guard_out <= ctrl_enable_q && (guard_s || guard_hold_q != '0);
      low_level_out <= ctrl_enable_q && ll_delayed;
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[`ST_TRIP_BIT] = trip_out;
    status[`ST_GUARD_BIT] = guard_out;
    status[`ST_LOW_LEVEL_BIT] = low_level_out;
    status[`ST_LOC_BIT] = loc;
    status[`ST_GUARD_OK_BIT] = guard_ok_q;
    status[`ST_ARMED_BIT] = armed_q;
    status[`ST_UB_LSB +: 2] = ub_state_q;
  end

  // No wait state: the answer is registered during the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !(paddr == `CTRL_OFFSET || paddr == `STATUS_OFFSET);
      if (pwrite || paddr == `CTRL_OFFSET) begin
        prdata <= pwrite ? 32'h0000_0000 : {31'h0000_0000, ctrl_enable_q};
      end else begin
        prdata <= (paddr == `STATUS_OFFSET) ? status : 32'h0000_0000;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// file: sim/trip_logic_checker.sv
// Port-level checks for the trip qualification block.
// Assumes binding to the block top; it sees only the top's ports.
module trip_logic_checker #(
  parameter int TICK_CYCLES = 10
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic trip_rx,
  input logic guard_rx,
  input logic low_level_rx,
  input logic noise_rx,
  input logic [7:0] dip_bank_a,
  input logic [7:0] dip_bank_b,
  input logic [7:0] dip_bank_c,
  input logic trip_out,
  input logic guard_out,
  input logic low_level_out
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  unmapped_err_a: assert property (psel && !penable &&
                                   paddr != 12'h000 && paddr != 12'h004 |=> pslverr)
    else $error("unmapped not refused");
  mapped_ok_a: assert property (psel && !penable &&
                                (paddr == 12'h000 || paddr == 12'h004) |=> !pslverr)
    else $error("mapped refused");
  err_data_a: assert property (access_s |-> !pslverr || pwrite || prdata == 32'h0000_0000)
    else $error("refused read data");
  rdata_hold_a: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved");
  trip_cause_a: assert property ($rose(trip_out) |-> $past(trip_rx, 3) || $past(low_level_rx, 3))
    else $error("trip without cause");
  guard_cause_a: assert property ($rose(guard_out) |-> $past(guard_rx, 3))
    else $error("guard without cause");
  low_cause_a: assert property ($rose(low_level_out) |-> $past(low_level_rx, 3))
    else $error("low level without cause");
endmodule

bind unblock_permissive_trip_logic trip_logic_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trip_rx(trip_rx), .guard_rx(guard_rx), .low_level_rx(low_level_rx), .noise_rx(noise_rx),
  .dip_bank_a(dip_bank_a), .dip_bank_b(dip_bank_b), .dip_bank_c(dip_bank_c),
  .trip_out(trip_out), .guard_out(guard_out), .low_level_out(low_level_out)
);

// file: sim/receiver_model.sv
// Receiver detector model feeding the block's detector inputs.
// Assumes the bench asks for levels as {noise, low level, guard, trip}.
module receiver_model (
  input logic pclk,
  input logic presetn,
  input logic [3:0] want,
  output logic trip_rx,
  output logic guard_rx,
  output logic low_level_rx,
  output logic noise_rx
);
  // Loss of channel is low level with guard gone, always asked for together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {noise_rx, low_level_rx, guard_rx, trip_rx} <= 4'h0;
    end else begin
      {noise_rx, low_level_rx, guard_rx, trip_rx} <= want;
    end
  end
endmodule

// file: sim/unblock_permissive_trip_logic_tb.sv
// Directed bench for the trip qualification block, one tick per 10 clocks.
// Assumes the receiver model and the bound checker are compiled with it.
module unblock_permissive_trip_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, err, trip_rx, guard_rx, low_level_rx, noise_rx;
  logic trip_out, guard_out, low_level_out;
  logic [7:0] bank_a = 8'h00, bank_b = 8'h00, bank_c = 8'h00;
  logic [3:0] want = 4'h0;
  logic [7:0] nb[3] = '{8'h05, 8'h00, 8'h01};
  logic [2:0] ne[3] = '{3'b001, 3'b001, 3'b101};
  logic [7:0] gb[3] = '{8'h08, 8'h10, 8'h18};
  int mismatches = 0, n_compared = 0, cycles = 0;

  unblock_permissive_trip_logic #(.TICK_CYCLES(10)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_rx(trip_rx), .guard_rx(guard_rx), .low_level_rx(low_level_rx), .noise_rx(noise_rx),
    .dip_bank_a(bank_a), .dip_bank_b(bank_b), .dip_bank_c(bank_c),
    .trip_out(trip_out), .guard_out(guard_out), .low_level_out(low_level_out)
  );
  receiver_model i_rx (
    .pclk(pclk), .presetn(presetn), .want(want), .trip_rx(trip_rx), .guard_rx(guard_rx),
    .low_level_rx(low_level_rx), .noise_rx(noise_rx)
  );

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // The whole run is about 30000 clocks; twice that means a hang.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic restart(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    presetn <= 1'b0;
    want <= 4'h0;
    bank_a <= a;
    bank_b <= b;
    bank_c <= c;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // Detector levels are {noise, low level, guard, trip}; times are in ticks.
  task automatic go(input logic [3:0] v, input int ms);
    want <= v;
    repeat (ms * 10) @(posedge pclk);
  endtask

  // Sampled mid-cycle so the edge's own updates have landed; the next drive waits for a
  // rising edge again.
  task automatic outs(input logic [2:0] e);
    @(negedge pclk);
    check(32'({trip_out, guard_out, low_level_out}), 32'(e), "outputs");
    @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n < 20), 32'h0000_0001, "no pready");
  endtask

  initial begin
    restart(8'h93, 8'h00, 8'h00);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(r, 32'h0000_0001, "ctrl reset");
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(32'({err, r[0]}), 32'h0000_0002, "unmapped");
    go(4'h1, 4);
    outs(3'b000);
    go(4'h1, 4);
    outs(3'b100);
    go(4'h0, 5);
    outs(3'b100);
    go(4'h0, 10);
    outs(3'b000);
    go(4'h2, 5);
    go(4'h0, 40);
    outs(3'b010);
    go(4'h0, 20);
    outs(3'b000);
    apb(1'b1, 12'h000, 32'h0000_0000);
    go(4'h3, 10);
    outs(3'b000);
    restart(8'h00, 8'h01, 8'h40);
    go(4'h2, 130);
    go(4'h4, 40);
    outs(3'b000);
    go(4'h4, 20);
    outs(3'b101);
    go(4'h4, 130);
    outs(3'b101);
    go(4'h4, 20);
    outs(3'b001);
    go(4'h3, 60);
    outs(3'b010);
    go(4'h2, 130);
    go(4'h1, 5);
    outs(3'b100);
    foreach (nb[i]) begin
      restart(8'h00, nb[i], 8'h00);
      go(4'h2, 130);
      go(4'hC, 20);
      outs(ne[i]);
    end
    foreach (gb[i]) begin
      restart(8'h00, gb[i], 8'h00);
      go(4'h1, 10);
      outs(3'b000);
      go(4'h2, 130);
      go(4'h1, 10);
      outs(3'b100);
    end
    restart(8'h00, 8'hF1, 8'h3F);
    go(4'h1, 1100);
    go(4'h4, 10);
    outs(3'b101);
    go(4'h2, 100);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(32'(r[5]), 32'h0000_0001, "armed");
    go(4'h2, 110);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(32'(r[5]), 32'h0000_0000, "disarmed");
    summarize();
  end
endmodule
